// >>> ipo_defines.svh
// constants of the in-position output logic
// Function
// RULE_01: policy 0 turns the output on whenever the deviation magnitude is below the window.
// RULE_02: policy 1 or 6 turns it on only with no position command and deviation below the window.
// RULE_03: policy 2 or 7 also needs the standstill flag on besides no command and a small deviation.
// RULE_04: policy 3 or 8 latches the output on at settling and keeps it on when a command arrives, until the hold time ends.
// RULE_05: after the hold time the output again follows command absence and the deviation test.
// RULE_06: command presence comes from the filtered command for policies 1-5, the raw one for 6-10.
// RULE_07: hold time 0 holds on until the next command; 1..30000 ms holds that long, dropped by a new command.
// RULE_08: policy 4 or 9 starts judging only once the hold time has passed after the command ends.
// RULE_09: the settle window is settable from 0 to 2097152 with default 10.
// RULE_10: the deviation magnitude is compared and the output is registered every clock cycle.
`ifndef IPO_DEFINES_SVH
`define IPO_DEFINES_SVH

// ----------------------------------------
// timing
// ----------------------------------------
`define IPO_CLK_NS 4
`define IPO_MS_NS 1000000
`define IPO_MS_CYCLES (`IPO_MS_NS / `IPO_CLK_NS)
`define IPO_TICK_W 18

// ----------------------------------------
// widths, limits, reset values
// ----------------------------------------
`define IPO_DEV_W 32
`define IPO_WIN_W 22
`define IPO_WIN_MAX 22'h200000
`define IPO_WIN_RST 22'h00000A
`define IPO_POL_W 4
`define IPO_POL_MAX 4'hA
`define IPO_POL_GROUP 4'h5
`define IPO_POL_RST 4'h0
`define IPO_HOLD_W 15
`define IPO_HOLD_MAX 15'h7530
`define IPO_HOLD_RST 15'h0000

// ----------------------------------------
// policy groups
// ----------------------------------------
`define IPO_MODE_PLAIN 4'h0
`define IPO_MODE_NOCMD 4'h1
`define IPO_MODE_STILL 4'h2
`define IPO_MODE_LATCH 4'h3
`define IPO_MODE_DELAY 4'h4

// ----------------------------------------
// register map, byte addresses
// ----------------------------------------
`define IPO_ADDR_W 4
`define IPO_OFS_WINDOW 4'h0
`define IPO_OFS_POLICY 4'h4
`define IPO_OFS_HOLD 4'h8
`define IPO_OFS_STATUS 4'hC

`endif

// >>> ipo_pkg.sv
// types of the in-position output logic
`default_nettype none
`include "ipo_defines.svh"
package ipo_pkg;

   typedef enum logic [2:0] {ST_FOLLOW, ST_LATCH, ST_HOLD, ST_WAIT, ST_JUDGE} ipo_state_t;

   typedef struct packed {
      logic [`IPO_WIN_W-1:0] window;
      logic [`IPO_POL_W-1:0] policy;
      logic [`IPO_HOLD_W-1:0] holdMs;
      logic waitReq;
      logic [31:0] rdata;
      ipo_state_t state;
      logic settled;
      logic below;
      logic cmdPrev;
      logic holdStart;
   } ipo_core_st_t;

   typedef struct packed {
      logic [`IPO_TICK_W-1:0] count;
      logic tick;
   } ipo_tick_st_t;

   typedef struct packed {
      logic [`IPO_HOLD_W-1:0] count;
      logic running;
      logic expired;
   } ipo_timer_st_t;

endpackage : ipo_pkg
`default_nettype wire

// >>> ipo_ms_tick.sv
// millisecond tick generator, restartable
`timescale 1ns/1ps
`default_nettype none
`include "ipo_defines.svh"
module ipo_ms_tick
   import ipo_pkg::*;
#(
   parameter int TICK_CYCLES = `IPO_MS_CYCLES
) (
   input wire logic clock,
   input wire logic nrst,
   input wire logic restart,
   output logic tick
);

   ipo_tick_st_t r_reg;
   ipo_tick_st_t r_next;

   always_comb begin
      r_next = r_reg;
      r_next.tick = 1'b0;
      if (restart) begin
         r_next.count = '0;
      end else if (r_reg.count == `IPO_TICK_W'(TICK_CYCLES - 1)) begin
         r_next.count = '0;
         r_next.tick = 1'b1;
      end else begin
         r_next.count = r_reg.count + `IPO_TICK_W'(1);
      end
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

   assign tick = r_reg.tick;

endmodule : ipo_ms_tick
`default_nettype wire

// >>> ipo_hold_timer.sv
// millisecond hold timer
`timescale 1ns/1ps
`default_nettype none
`include "ipo_defines.svh"
module ipo_hold_timer
   import ipo_pkg::*;
(
   input wire logic clock,
   input wire logic nrst,
   input wire logic start,
   input wire logic [`IPO_HOLD_W-1:0] loadMs,
   input wire logic msTick,
   output logic running,
   output logic expired
);

   ipo_timer_st_t r_reg;
   ipo_timer_st_t r_next;

   always_comb begin
      r_next = r_reg;
      r_next.expired = 1'b0;
      if (start) begin
         r_next.count = loadMs;
         r_next.running = (loadMs != '0);
      end else if (r_reg.running && msTick) begin
         if (r_reg.count == `IPO_HOLD_W'(1)) begin
            r_next.running = 1'b0;
            r_next.expired = 1'b1; // RULE_07
         end
         r_next.count = r_reg.count - `IPO_HOLD_W'(1);
      end
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

   assign running = r_reg.running;
   assign expired = r_reg.expired;

endmodule : ipo_hold_timer
`default_nettype wire

// >>> ipo_core.sv
// in-position output logic with avalon register slave
`timescale 1ns/1ps
`default_nettype none
`include "ipo_defines.svh"
module ipo_core
   import ipo_pkg::*;
#(
   parameter int MS_CYCLES = `IPO_MS_CYCLES
) (
   input wire logic clock,
   input wire logic nrst,
   input wire logic [`IPO_ADDR_W-1:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [3:0] byteenable,
   output logic [31:0] readdata,
   output logic waitrequest,
   input wire logic signed [`IPO_DEV_W-1:0] positionDeviation,
   input wire logic cmdFilteredPresent,
   input wire logic cmdRawPresent,
   input wire logic nearStandstillFlag,
   output logic inPositionFlag
);

   // ----------------------------------------
   // state
   // ----------------------------------------
   ipo_core_st_t r_reg;
   ipo_core_st_t r_next;
   logic msTick;
   logic timerRunning;
   logic timerExpired;
   logic [`IPO_DEV_W-1:0] absDev;
   logic belowNow;
   logic cmdNow;
   logic cmdRise;
   logic cmdFall;
   logic noCmdBelow;
   logic [`IPO_POL_W-1:0] mode;
   logic [31:0] beMask;
   logic [31:0] oldWord;
   logic [31:0] newWord;

   // ----------------------------------------
   // timers
   // ----------------------------------------
   ipo_ms_tick #(
      .TICK_CYCLES(MS_CYCLES)
   ) u_tick (
      .clock(clock),
      .nrst(nrst),
      .restart(r_reg.holdStart),
      .tick(msTick)
   );

   ipo_hold_timer u_timer (
      .clock(clock),
      .nrst(nrst),
      .start(r_reg.holdStart),
      .loadMs(r_reg.holdMs),
      .msTick(msTick),
      .running(timerRunning),
      .expired(timerExpired)
   );

   // ----------------------------------------
   // judgment terms
   // ----------------------------------------
   always_comb begin
      if (positionDeviation[`IPO_DEV_W-1]) begin
         absDev = `IPO_DEV_W'(-positionDeviation); // RULE_10
      end else begin
         absDev = positionDeviation;
      end
      belowNow = (absDev < `IPO_DEV_W'(r_reg.window)); // RULE_10
      if (r_reg.policy > `IPO_POL_GROUP) begin
         cmdNow = cmdRawPresent; // RULE_06
         mode = `IPO_POL_W'(r_reg.policy - `IPO_POL_GROUP);
      end else begin
         cmdNow = cmdFilteredPresent; // RULE_06
         mode = r_reg.policy;
      end
      cmdRise = cmdNow && !r_reg.cmdPrev;
      cmdFall = !cmdNow && r_reg.cmdPrev;
      noCmdBelow = !cmdNow && belowNow;
   end

   // ----------------------------------------
   // bus write merge
   // ----------------------------------------
   always_comb begin
      beMask = {{8{byteenable[3]}}, {8{byteenable[2]}}, {8{byteenable[1]}}, {8{byteenable[0]}}};
      unique case (address)
         `IPO_OFS_WINDOW: oldWord = 32'(r_reg.window);
         `IPO_OFS_POLICY: oldWord = 32'(r_reg.policy);
         `IPO_OFS_HOLD: oldWord = 32'(r_reg.holdMs);
         `IPO_OFS_STATUS: oldWord = {28'h0000000, timerRunning, cmdNow, r_reg.below, r_reg.settled};
         default: oldWord = 32'h00000000;
      endcase
      newWord = (oldWord & ~beMask) | (writedata & beMask);
   end

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      r_next = r_reg;
      r_next.holdStart = 1'b0;
      r_next.below = belowNow;
      r_next.cmdPrev = cmdNow;
      unique case (mode)
         `IPO_MODE_PLAIN: begin
            r_next.settled = belowNow; // RULE_01
            r_next.state = ST_FOLLOW;
         end
         `IPO_MODE_NOCMD: begin
            r_next.settled = noCmdBelow; // RULE_02
            r_next.state = ST_FOLLOW;
         end
         `IPO_MODE_STILL: begin
            r_next.settled = noCmdBelow && nearStandstillFlag; // RULE_03
            r_next.state = ST_FOLLOW;
         end
         `IPO_MODE_LATCH: begin
            unique case (r_reg.state)
               ST_LATCH: begin
                  r_next.settled = 1'b1; // RULE_04
                  if (cmdNow && (r_reg.holdMs == `IPO_HOLD_RST)) begin
                     r_next.settled = 1'b0; // RULE_07
                     r_next.state = ST_FOLLOW;
                  end else if (cmdNow) begin
                     r_next.state = ST_HOLD; // RULE_04
                     r_next.holdStart = 1'b1;
                  end
               end
               ST_HOLD: begin
                  r_next.settled = 1'b1; // RULE_04
                  // stale expiry of an earlier run ignored in the load cycle
                  if (cmdRise || (timerExpired && !r_reg.holdStart)) begin
                     r_next.settled = noCmdBelow; // RULE_05
                     r_next.state = ST_FOLLOW; // RULE_07
                  end
               end
               default: begin
                  r_next.settled = noCmdBelow; // RULE_05
                  r_next.state = noCmdBelow ? ST_LATCH : ST_FOLLOW;
               end
            endcase
         end
         `IPO_MODE_DELAY: begin
            unique case (r_reg.state)
               ST_JUDGE: begin
                  r_next.settled = noCmdBelow; // RULE_08
                  if (cmdNow) begin
                     r_next.state = ST_WAIT;
                  end
               end
               ST_WAIT: begin
                  r_next.settled = 1'b0;
                  if (cmdFall && (r_reg.holdMs == `IPO_HOLD_RST)) begin
                     r_next.state = ST_JUDGE;
                  end else if (cmdFall) begin
                     r_next.holdStart = 1'b1; // RULE_08
                  end else if (timerExpired && !r_reg.holdStart && !cmdNow) begin
                     r_next.state = ST_JUDGE; // RULE_08
                  end
               end
               default: begin
                  r_next.settled = 1'b0;
                  r_next.state = cmdNow ? ST_WAIT : ST_JUDGE;
               end
            endcase
         end
         default: begin
            r_next.settled = 1'b0;
            r_next.state = ST_FOLLOW;
         end
      endcase

      // avalon slave: one wait cycle, then answer
      r_next.waitReq = 1'b1;
      if ((read || write) && r_reg.waitReq) begin
         r_next.waitReq = 1'b0;
         r_next.rdata = read ? oldWord : 32'h00000000;
      end
      if (write && !r_reg.waitReq) begin
         unique case (address)
            `IPO_OFS_WINDOW: begin
               if (newWord > 32'(`IPO_WIN_MAX)) begin
                  r_next.window = `IPO_WIN_MAX; // RULE_09
               end else begin
                  r_next.window = newWord[`IPO_WIN_W-1:0]; // RULE_09
               end
            end
            `IPO_OFS_POLICY: begin
               if (newWord <= 32'(`IPO_POL_MAX)) begin
                  r_next.policy = newWord[`IPO_POL_W-1:0];
                  r_next.state = ST_FOLLOW;
               end
            end
            `IPO_OFS_HOLD: begin
               if (newWord > 32'(`IPO_HOLD_MAX)) begin
                  r_next.holdMs = `IPO_HOLD_MAX; // RULE_07
               end else begin
                  r_next.holdMs = newWord[`IPO_HOLD_W-1:0];
               end
            end
            default: begin
            end
         endcase
      end
   end

   // ----------------------------------------
   // registers
   // ----------------------------------------
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         r_reg.window <= `IPO_WIN_RST; // RULE_09
         r_reg.policy <= `IPO_POL_RST;
         r_reg.holdMs <= `IPO_HOLD_RST;
         r_reg.waitReq <= 1'b1;
         r_reg.rdata <= 32'h00000000;
         r_reg.state <= ST_FOLLOW;
         r_reg.settled <= 1'b0;
         r_reg.below <= 1'b0;
         r_reg.cmdPrev <= 1'b0;
         r_reg.holdStart <= 1'b0;
      end else begin
         r_reg <= r_next;
      end
   end

   assign readdata = r_reg.rdata;
   assign waitrequest = r_reg.waitReq;
   assign inPositionFlag = r_reg.settled;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!nrst);

   property p_plain_on;
      nrst && (r_reg.policy == `IPO_POL_RST) && !write |-> (belowNow |=> inPositionFlag) and
         (!belowNow |=> !inPositionFlag);
   endproperty
   a_plain_on: assert property (p_plain_on) else $error("policy 0 output wrong"); // RULE_01

   property p_nocmd;
      (mode == `IPO_MODE_NOCMD) && cmdNow && !write |=> !inPositionFlag;
   endproperty
   a_nocmd: assert property (p_nocmd) else $error("on with command present"); // RULE_02

   property p_still;
      (mode == `IPO_MODE_STILL) && !nearStandstillFlag && !write |=> !inPositionFlag;
   endproperty
   a_still: assert property (p_still) else $error("on without standstill"); // RULE_03

   property p_hold_on;
      (r_reg.state == ST_HOLD) || (r_reg.state == ST_LATCH) |-> inPositionFlag;
   endproperty
   a_hold_on: assert property (p_hold_on) else $error("latched output dropped"); // RULE_04

   property p_hold_end;
      (r_reg.state == ST_HOLD) && timerExpired && !r_reg.holdStart && !write |=>
         (inPositionFlag == $past(noCmdBelow)) && (r_reg.state == ST_FOLLOW);
   endproperty
   a_hold_end: assert property (p_hold_end) else $error("hold end not followed"); // RULE_05

   property p_raw_src;
      (r_reg.policy > `IPO_POL_GROUP) && (mode != `IPO_MODE_LATCH) && cmdRawPresent && !write
         |=> !inPositionFlag;
   endproperty
   a_raw_src: assert property (p_raw_src) else $error("raw command ignored"); // RULE_06

   property p_wait_off;
      (r_reg.state == ST_WAIT) |-> !inPositionFlag;
   endproperty
   a_wait_off: assert property (p_wait_off) else $error("on before delay passed"); // RULE_08

   property p_window_max;
      r_reg.window <= `IPO_WIN_MAX;
   endproperty
   a_window_max: assert property (p_window_max) else $error("window above limit"); // RULE_09

   property p_bus_ack;
      (read || write) && waitrequest |=> !waitrequest ##1 waitrequest;
   endproperty
   a_bus_ack: assert property (p_bus_ack) else $error("bus answer timing wrong");

endmodule : ipo_core
`default_nettype wire

// >>> ipo_host_model.sv
// host side motion model driving command, deviation and standstill
`timescale 1ns/1ps
`default_nettype none
module ipo_host_model #(
   parameter int FILT = 3
) (
   input wire logic clock,
   input wire logic nrst,
   input wire logic cmdReq,
   input wire logic signed [31:0] devReq,
   input wire logic stillReq,
   output logic signed [31:0] dev,
   output logic cmdRaw,
   output logic cmdFilt,
   output logic still
);
   // ----------------------------------------
   // raw command now, filtered one lags it by FILT-1
   // ----------------------------------------
   logic [7:0] pipeReg;
   always @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         dev <= 32'sh0;
         cmdRaw <= 1'b0;
         pipeReg <= 8'h00;
         still <= 1'b0;
      end else begin
         dev <= devReq;
         cmdRaw <= cmdReq;
         pipeReg <= {pipeReg[6:0], cmdReq};
         still <= stillReq;
      end
   end
   assign cmdFilt = pipeReg[FILT-1];
endmodule : ipo_host_model
`default_nettype wire

// >>> ipo_core_tb.sv
// self-checking bench of the in-position output logic
`timescale 1ns/1ps
`default_nettype none
`include "ipo_defines.svh"
module ipo_core_tb
   import ipo_pkg::*;
;
   localparam int MSC = 10;
   logic clock = 1'b0, nrst = 1'b0, read = 1'b0, write = 1'b0;
   logic cmdReq = 1'b0, stillReq = 1'b0;
   logic [3:0] address = 4'h0;
   logic [31:0] writedata = 32'h0, rd, readdata;
   logic signed [31:0] devReq = 32'sh0, dev;
   logic waitrequest, cmdRaw, cmdFilt, still, inPositionFlag;
   int errCount = 0, numChecks = 0, seed = 96573;
   int winM = 10, polM = 0, holdM = 0, st = 0, tmr = 0, skip = 2;
   bit expF = 1'b0, cPrev = 1'b0;

   always #2 clock = ~clock;

   ipo_host_model ipo_host_model_i (.clock(clock), .nrst(nrst), .cmdReq(cmdReq),
      .devReq(devReq), .stillReq(stillReq), .dev(dev), .cmdRaw(cmdRaw),
      .cmdFilt(cmdFilt), .still(still));

   ipo_core #(.MS_CYCLES(MSC)) ipo_core_i (.clock(clock), .nrst(nrst), .address(address),
      .read(read), .write(write), .writedata(writedata), .byteenable(4'hF),
      .readdata(readdata), .waitrequest(waitrequest), .positionDeviation(dev),
      .cmdFilteredPresent(cmdFilt), .cmdRawPresent(cmdRaw),
      .nearStandstillFlag(still), .inPositionFlag(inPositionFlag));

   // ----------------------------------------
   // reference model, one cycle latency
   // ----------------------------------------
   always @(posedge clock) begin
      int p, m;
      bit c, b;
      longint a;
      p = polM;
      m = (p > 5) ? p - 5 : p;
      if (!nrst) begin
         expF = 1'b0;
         st = 0;
      end else begin
         if (skip > 0) skip--;
         else if (m != 4) begin
            numChecks++;
            if (inPositionFlag !== expF) begin
               errCount++;
               $display("MISMATCH inPositionFlag exp %0b got %b", expF, inPositionFlag);
            end
         end
         c = (p > 5) ? cmdRaw : cmdFilt;
         a = dev;
         if (a < 0) a = -a;
         b = a < winM;
         case (m)
            0: expF = b;
            1: expF = !c && b;
            2: expF = !c && b && still;
            3: begin
               if (st == 0) begin
                  expF = !c && b;
                  if (expF) st = 1;
               end else if (st == 1) begin
                  expF = 1'b1;
                  if (c && holdM == 0) begin
                     expF = 1'b0;
                     st = 0;
                  end else if (c) begin
                     st = 2;
                     tmr = holdM * MSC + 3;
                  end
               end else begin
                  tmr--;
                  expF = 1'b1;
                  if ((c && !cPrev) || tmr <= 0) begin
                     expF = !c && b;
                     st = 0;
                  end
               end
            end
            default: expF = 1'b0;
         endcase
         cPrev = c;
      end
   end

   // ----------------------------------------
   // bus and check tasks
   // ----------------------------------------
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      numChecks++;
      if (g !== e) begin
         errCount++;
         $display("MISMATCH %s exp %h got %h", nm, e, g);
      end
   endtask : chk

   task automatic bus(input bit wr, input logic [3:0] a, input logic [31:0] d);
      int n;
      @(posedge clock);
      address <= a;
      write <= wr;
      read <= !wr;
      writedata <= d;
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (waitrequest !== 1'b0);
      rd = readdata;
      read <= 1'b0;
      write <= 1'b0;
      chk("bus cycles", 32'h2, n);
   endtask : bus

   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
      // model follows the register from the edge after the write lands
      @(negedge clock);
      if (a == 4'h0) winM = (d > 32'h200000) ? 32'h200000 : d;
      if (a == 4'h4 && d <= 32'hA) begin
         polM = d;
         st = 0;
      end
      if (a == 4'h8) holdM = (d > 32'h7530) ? 32'h7530 : d;
      skip = 3;
   endtask : wr

   task automatic rdchk(input logic [3:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk("readdata", e, rd);
   endtask : rdchk

   task automatic wander(input int segs);
      int len, k;
      repeat (segs) begin
         len = 1 + ($unsigned($random(seed)) % 30);
         k = $unsigned($random(seed)) % 4;
         repeat (len) begin
            @(posedge clock);
            cmdReq <= (k == 0);
            stillReq <= (k != 1);
            devReq <= $random(seed) % ((k == 3) ? 40 : 12);
         end
      end
   endtask : wander

   task automatic stopTest;
      $display("checks %0d errors %0d", numChecks, errCount);
      if (errCount == 0 && numChecks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : stopTest

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   initial begin
      int i;
      repeat (2) @(posedge clock);
      nrst <= 1'b1;
      rdchk(4'h0, 32'hA);
      rdchk(4'h4, 32'h0);
      rdchk(4'h8, 32'h0);
      rdchk(4'h2, 32'h0);
      rdchk(4'hC, 32'h3);
      wr(4'h4, 32'hB);
      rdchk(4'h4, 32'h0);
      wr(4'h0, 32'h300000);
      rdchk(4'h0, 32'h200000);
      wr(4'h0, 32'hA);
      wr(4'h8, 32'h9C40);
      rdchk(4'h8, 32'h7530);
      wr(4'h8, 32'h2);
      for (i = 0; i <= 10; i++) begin
         wr(4'h4, i);
         wander(20);
      end
      // delayed judgment after command end
      @(posedge clock);
      cmdReq <= 1'b1;
      devReq <= 32'sh0;
      wr(4'h4, 32'h4);
      repeat (10) @(posedge clock);
      cmdReq <= 1'b0;
      for (i = 0; i < 60; i++) begin
         @(posedge clock);
         if (i < 20) chk("delayed flag", 32'h0, {31'h0, inPositionFlag});
         if (inPositionFlag === 1'b1) break;
      end
      chk("delayed flag", 32'h1, {31'h0, inPositionFlag});
      wr(4'h8, 32'h0);
      wr(4'h4, 32'h3);
      wander(20);
      wr(4'h4, 32'h8);
      wander(20);
      stopTest();
   end

   initial begin
      #(4 * 60000);
      errCount++;
      stopTest();
   end
endmodule : ipo_core_tb
`default_nettype wire
